// [src/ualc_pkg.sv]
package ualc_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses, one word each)
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W        = 8;
  localparam logic [7:0] OFS_GAP        = 8'h00;
  localparam logic [7:0] OFS_RATIO      = 8'h04;
  localparam logic [7:0] OFS_ERRCNT     = 8'h08;
  localparam logic [7:0] OFS_MAN        = 8'h0C;
  localparam logic [7:0] OFS_IRFILT     = 8'h10;
  localparam logic [7:0] OFS_IRQ_STAT   = 8'h14;
  localparam logic [7:0] OFS_IRQ_MASK   = 8'h18;

  // ----------------------------------------------------------------
  // widths and reset values
  // ----------------------------------------------------------------
  localparam int unsigned GAP_W         = 8;
  localparam int unsigned RATIO_W       = 11;
  localparam int unsigned ERR_W         = 8;
  localparam int unsigned FILT_W        = 8;
  localparam int unsigned PLEN_W        = 4;
  localparam int unsigned IRQ_W         = 5;
  localparam logic [10:0] RATIO_RST     = 11'h174;
  localparam logic [31:0] ZERO_WORD     = 32'h0000_0000;

  // ----------------------------------------------------------------
  // manchester configuration field positions
  // ----------------------------------------------------------------
  localparam int unsigned MAN_TX_LEN_LO = 0;
  localparam int unsigned MAN_TX_KND_LO = 8;
  localparam int unsigned MAN_TX_POL    = 12;
  localparam int unsigned MAN_RX_LEN_LO = 16;
  localparam int unsigned MAN_RX_KND_LO = 24;
  localparam int unsigned MAN_RX_POL    = 28;
  localparam int unsigned MAN_DRIFT     = 30;

  // ----------------------------------------------------------------
  // interrupt status bit positions
  // ----------------------------------------------------------------
  localparam int unsigned IRQ_CARD_ERR  = 0;
  localparam int unsigned IRQ_PRE_ERR   = 1;
  localparam int unsigned IRQ_PRE_OK    = 2;
  localparam int unsigned IRQ_GAP_DONE  = 3;
  localparam int unsigned IRQ_DRIFT_CFG = 4;

  // ----------------------------------------------------------------
  // preamble kinds and transmit sequencer states
  // ----------------------------------------------------------------
  localparam logic [1:0] KIND_ALL_ONE   = 2'h0;
  localparam logic [1:0] KIND_ALL_ZERO  = 2'h1;
  localparam logic [1:0] KIND_ZERO_ONE  = 2'h2;
  localparam logic [1:0] KIND_ONE_ZERO  = 2'h3;

  typedef enum logic [1:0] {
    TX_IDLE     = 2'b00,
    TX_PREAMBLE = 2'b01,
    TX_FRAME    = 2'b10,
    TX_GUARD    = 2'b11
  } ualc_tx_e;

  typedef struct packed {
    logic              drift;
    logic              rx_pol;
    logic [1:0]        rx_kind;
    logic [PLEN_W-1:0] rx_len;
    logic              tx_pol;
    logic [1:0]        tx_kind;
    logic [PLEN_W-1:0] tx_len;
  } ualc_man_s;

  // one bit cell on the line: level in first half, level in second half
  typedef struct packed {
    logic first;
    logic second;
  } ualc_sym_s;

  // logical preamble bit for a kind at a given bit index
  function automatic logic pattern_bit(input logic [1:0] kind, input logic [PLEN_W-1:0] idx);
    logic b;
    b = 1'b1;
    case (kind)
      KIND_ALL_ONE:  b = 1'b1;
      KIND_ALL_ZERO: b = 1'b0;
      KIND_ZERO_ONE: b = idx[0];
      default:       b = ~idx[0];
    endcase
    return b;
  endfunction

  // biphase encode: clear polarity gives zero as low-to-high
  function automatic ualc_sym_s encode(input logic b, input logic pol);
    ualc_sym_s s;
    s.first  = b ^ pol;
    s.second = ~(b ^ pol);
    return s;
  endfunction

endpackage

// [src/ualc_pulse_filt.sv]
`timescale 1ns/1ps
module ualc_pulse_filt
  import ualc_pkg::*;
#(
  parameter int unsigned W = FILT_W
) (
  input  wire logic         mclk,
  input  wire logic         sys_rst,
  input  wire logic         din,
  input  wire logic [W-1:0] setting,
  output logic              dout_r
);
  logic [W-1:0] run_r;
  logic         differs;

  assign differs = din != dout_r;

  // follow after setting+1 differing clocks
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      run_r  <= '0;
      dout_r <= 1'b1;
    end else if (!differs) begin
      run_r  <= '0;
    end else if (run_r >= setting) begin
      run_r  <= '0;
      dout_r <= din;
    end else begin
      run_r  <= run_r + W'(1);
    end
  end
endmodule

// [src/ualc_ratio_div.sv]
`timescale 1ns/1ps
module ualc_ratio_div
  import ualc_pkg::*;
#(
  parameter int unsigned W = RATIO_W
) (
  input  wire logic         mclk,
  input  wire logic         sys_rst,
  input  wire logic         sck_tick,
  input  wire logic [W-1:0] ratio,
  output logic              tick_r
);
  logic [W-1:0] cnt_r;
  logic         wrap;

  // zero ratio never wraps, so never ticks
  assign wrap = (ratio != '0) && sck_tick && (cnt_r >= ratio - W'(1));

  // one output tick per ratio serial ticks
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cnt_r  <= '0;
      tick_r <= 1'b0;
    end else begin
      tick_r <= wrap;
      if (wrap || ratio == '0) begin
        cnt_r <= '0;
      end else if (sck_tick) begin
        cnt_r <= cnt_r + W'(1);
      end
    end
  end
endmodule

// [src/ualc_top.sv]
// Behaviour
// - zero gap disables, else gap times bit
// - smartcard ratio zero gives no baud tick
// - smartcard baud equals sck divided by ratio
// - read-only eight-bit smartcard error tally
// - reading error tally clears it
// - send preamble length zero disables, else bits
// - send kind: ones, zeros, zero-one, one-zero
// - per-direction polarity swaps transition meaning
// - receive preamble length zero disables detection
// - receive kind uses same four codes
// - drift tolerance needs sixteen-times oversampling
// - eight-bit filter rejects short infrared pulses
//
// Chosen here: the APB slave port and the register addresses.
`timescale 1ns/1ps
module ualc_top
  import ualc_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              sys_rst,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              smartcard_mode,
  input  wire logic              manchester_en,
  input  wire logic              over16_mode,
  input  wire logic              bit_tick_in,
  input  wire logic              sck_tick,
  input  wire logic              card_error,
  input  wire logic              frame_req,
  input  wire logic              char_done,
  output logic                   tx_ready,
  output logic                   frame_go,
  output logic                   tx_hold,
  output logic                   tx_pre_active,
  output ualc_sym_s              tx_pre_sym,
  input  wire logic              rx_sym_valid,
  input  wire ualc_sym_s         rx_sym,
  output logic                   rx_pre_ok,
  output logic                   rx_pre_err,
  input  wire logic              ir_rx_raw,
  output logic                   ir_rx_clean,
  output logic                   baud_tick,
  output logic                   drift_enable,
  output logic                   irq
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [GAP_W-1:0]   gap_delay_value_r;
  logic [RATIO_W-1:0] smartcard_divide_ratio_r;
  logic [ERR_W-1:0]   error_tally_r;
  logic [ERR_W-1:0]   error_tally_nxt;
  ualc_man_s          man_r;
  logic [FILT_W-1:0]  ir_filter_r;
  logic [IRQ_W-1:0]   irq_stat_r;
  logic [IRQ_W-1:0]   irq_stat_nxt;
  logic [IRQ_W-1:0]   irq_mask_r;
  logic [IRQ_W-1:0]   irq_event;
  logic [31:0]        prdata_r;
  logic               pslverr_r;

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  logic        setup_ph;
  logic        access_ph;
  logic        wr_en;
  logic        rd_setup;
  logic        hit_gap;
  logic        hit_ratio;
  logic        hit_err;
  logic        hit_man;
  logic        hit_filt;
  logic        hit_stat;
  logic        hit_mask;
  logic        hit_any;
  logic        tally_clear;
  logic [31:0] rd_word;

  // address decode and phase qualifiers
  assign setup_ph    = psel && !penable;
  assign access_ph   = psel && penable;
  assign hit_gap     = paddr == OFS_GAP;
  assign hit_ratio   = paddr == OFS_RATIO;
  assign hit_err     = paddr == OFS_ERRCNT;
  assign hit_man     = paddr == OFS_MAN;
  assign hit_filt    = paddr == OFS_IRFILT;
  assign hit_stat    = paddr == OFS_IRQ_STAT;
  assign hit_mask    = paddr == OFS_IRQ_MASK;
  assign hit_any     = hit_gap | hit_ratio | hit_err | hit_man | hit_filt | hit_stat | hit_mask;
  assign wr_en       = access_ph && pwrite && hit_any;
  assign rd_setup    = setup_ph && !pwrite;
  assign tally_clear = rd_setup && hit_err;

  // read data mux, reserved bits read zero
  always_comb begin
    rd_word = ZERO_WORD;
    if (hit_gap) begin
      rd_word[GAP_W-1:0] = gap_delay_value_r;
    end else if (hit_ratio) begin
      rd_word[RATIO_W-1:0] = smartcard_divide_ratio_r;
    end else if (hit_err) begin
      rd_word[ERR_W-1:0] = error_tally_r;
    end else if (hit_man) begin
      rd_word[MAN_TX_LEN_LO +: PLEN_W] = man_r.tx_len;
      rd_word[MAN_TX_KND_LO +: 2]      = man_r.tx_kind;
      rd_word[MAN_TX_POL]              = man_r.tx_pol;
      rd_word[MAN_RX_LEN_LO +: PLEN_W] = man_r.rx_len;
      rd_word[MAN_RX_KND_LO +: 2]      = man_r.rx_kind;
      rd_word[MAN_RX_POL]              = man_r.rx_pol;
      rd_word[MAN_DRIFT]               = man_r.drift;
    end else if (hit_filt) begin
      rd_word[FILT_W-1:0] = ir_filter_r;
    end else if (hit_stat) begin
      rd_word[IRQ_W-1:0] = irq_stat_r;
    end else if (hit_mask) begin
      rd_word[IRQ_W-1:0] = irq_mask_r;
    end
  end

  // no wait states, error on unmapped address
  assign pready  = 1'b1;
  assign prdata  = prdata_r;
  assign pslverr = pslverr_r && access_ph;

  // read data and error flag taken at setup
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      prdata_r  <= ZERO_WORD;
      pslverr_r <= 1'b0;
    end else if (setup_ph) begin
      prdata_r  <= pwrite ? ZERO_WORD : rd_word;
      pslverr_r <= !hit_any;
    end
  end

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  // writes land at the access edge
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      gap_delay_value_r        <= '0;
      smartcard_divide_ratio_r <= RATIO_RST;
      man_r                    <= '0;
      ir_filter_r              <= '0;
      irq_mask_r               <= '0;
    end else if (wr_en) begin
      if (hit_gap) begin
        gap_delay_value_r <= pwdata[GAP_W-1:0];
      end
      if (hit_ratio) begin
        smartcard_divide_ratio_r <= pwdata[RATIO_W-1:0];
      end
      if (hit_man) begin
        man_r.tx_len  <= pwdata[MAN_TX_LEN_LO +: PLEN_W];
        man_r.tx_kind <= pwdata[MAN_TX_KND_LO +: 2];
        man_r.tx_pol  <= pwdata[MAN_TX_POL];
        man_r.rx_len  <= pwdata[MAN_RX_LEN_LO +: PLEN_W];
        man_r.rx_kind <= pwdata[MAN_RX_KND_LO +: 2];
        man_r.rx_pol  <= pwdata[MAN_RX_POL];
        man_r.drift   <= pwdata[MAN_DRIFT];
      end
      if (hit_filt) begin
        ir_filter_r <= pwdata[FILT_W-1:0];
      end
      if (hit_mask) begin
        irq_mask_r <= pwdata[IRQ_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // smartcard error tally
  // ----------------------------------------------------------------
  logic card_err_hit;

  // an error in the clearing cycle counts one
  assign card_err_hit = card_error && smartcard_mode;

  always_comb begin
    error_tally_nxt = error_tally_r;
    if (tally_clear) begin
      error_tally_nxt = card_err_hit ? ERR_W'(1) : '0;
    end else if (card_err_hit && error_tally_r != '1) begin
      error_tally_nxt = error_tally_r + ERR_W'(1);
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      error_tally_r <= '0;
    end else begin
      error_tally_r <= error_tally_nxt;
    end
  end

  // ----------------------------------------------------------------
  // bit clock selection
  // ----------------------------------------------------------------
  logic sc_tick;

  ualc_ratio_div #(
    .W (RATIO_W)
  ) u_ratio_div (
    .mclk     (mclk),
    .sys_rst  (sys_rst),
    .sck_tick (sck_tick),
    .ratio    (smartcard_divide_ratio_r),
    .tick_r   (sc_tick)
  );

  // smartcard mode takes the divided serial clock
  assign baud_tick = smartcard_mode ? sc_tick : bit_tick_in;

  // ----------------------------------------------------------------
  // transmit sequencer: preamble, frame, guard
  // ----------------------------------------------------------------
  ualc_tx_e           tx_state_r;
  ualc_tx_e           tx_state_nxt;
  logic [GAP_W-1:0]   tx_cnt_r;
  logic [GAP_W-1:0]   tx_cnt_nxt;
  logic               pre_wanted;
  logic               pre_last;
  logic               gap_last;
  logic               gap_done;
  logic [PLEN_W-1:0]  pre_idx;

  assign pre_wanted = manchester_en && man_r.tx_len != '0;
  assign pre_idx    = tx_cnt_r[PLEN_W-1:0];
  assign pre_last   = baud_tick && pre_idx == man_r.tx_len - PLEN_W'(1);
  assign gap_last   = baud_tick && tx_cnt_r == gap_delay_value_r - GAP_W'(1);
  assign gap_done   = tx_state_r == TX_GUARD && gap_last;

  // next state and counter
  always_comb begin
    tx_state_nxt = tx_state_r;
    tx_cnt_nxt   = tx_cnt_r;
    frame_go     = 1'b0;
    case (tx_state_r)
      TX_IDLE: begin
        tx_cnt_nxt = '0;
        if (frame_req && pre_wanted) begin
          tx_state_nxt = TX_PREAMBLE;
        end else if (frame_req) begin
          tx_state_nxt = TX_FRAME;
          frame_go     = 1'b1;
        end
      end
      TX_PREAMBLE: begin
        if (pre_last) begin
          tx_state_nxt = TX_FRAME;
          tx_cnt_nxt   = '0;
          frame_go     = 1'b1;
        end else if (baud_tick) begin
          tx_cnt_nxt = tx_cnt_r + GAP_W'(1);
        end
      end
      TX_FRAME: begin
        if (char_done && gap_delay_value_r != '0) begin
          tx_state_nxt = TX_GUARD;
          tx_cnt_nxt   = '0;
        end else if (char_done) begin
          tx_state_nxt = TX_IDLE;
        end
      end
      default: begin
        if (gap_last) begin
          tx_state_nxt = TX_IDLE;
          tx_cnt_nxt   = '0;
        end else if (baud_tick) begin
          tx_cnt_nxt = tx_cnt_r + GAP_W'(1);
        end
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      tx_state_r <= TX_IDLE;
      tx_cnt_r   <= '0;
    end else begin
      tx_state_r <= tx_state_nxt;
      tx_cnt_r   <= tx_cnt_nxt;
    end
  end

  // handshake status of the sequencer
  assign tx_ready = tx_state_r == TX_IDLE;
  assign tx_hold  = tx_state_r == TX_GUARD;

  // registered preamble cell for the line driver
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      tx_pre_active <= 1'b0;
      tx_pre_sym    <= '0;
    end else begin
      tx_pre_active <= tx_state_nxt == TX_PREAMBLE;
      tx_pre_sym    <= encode(pattern_bit(man_r.tx_kind, tx_cnt_nxt[PLEN_W-1:0]), man_r.tx_pol);
    end
  end

  // ----------------------------------------------------------------
  // receive preamble checker
  // ----------------------------------------------------------------
  logic [PLEN_W-1:0] rx_idx_r;
  logic              rx_bit;
  logic              rx_bad_cell;
  logic              rx_match;
  logic              rx_check;

  // equal halves are no valid cell
  assign rx_bit      = rx_sym.first ^ man_r.rx_pol;
  assign rx_bad_cell = rx_sym.first == rx_sym.second;
  assign rx_check    = rx_sym_valid && manchester_en && man_r.rx_len != '0;
  assign rx_match    = !rx_bad_cell && rx_bit == pattern_bit(man_r.rx_kind, rx_idx_r);

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rx_idx_r   <= '0;
      rx_pre_ok  <= 1'b0;
      rx_pre_err <= 1'b0;
    end else begin
      rx_pre_ok  <= 1'b0;
      rx_pre_err <= 1'b0;
      if (!rx_check) begin
        rx_idx_r <= (man_r.rx_len == '0) ? '0 : rx_idx_r;
      end else if (!rx_match) begin
        rx_idx_r   <= '0;
        rx_pre_err <= 1'b1;
      end else if (rx_idx_r == man_r.rx_len - PLEN_W'(1)) begin
        rx_idx_r  <= '0;
        rx_pre_ok <= 1'b1;
      end else begin
        rx_idx_r <= rx_idx_r + PLEN_W'(1);
      end
    end
  end

  // ----------------------------------------------------------------
  // drift and infrared filter
  // ----------------------------------------------------------------
  // drift needs sixteen-times sampling
  assign drift_enable = man_r.drift && over16_mode;

  ualc_pulse_filt #(
    .W (FILT_W)
  ) u_pulse_filt (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .din     (ir_rx_raw),
    .setting (ir_filter_r),
    .dout_r  (ir_rx_clean)
  );

  // ----------------------------------------------------------------
  // interrupts
  // ----------------------------------------------------------------
  // events; set wins over a same-cycle clear
  always_comb begin
    irq_event                = '0;
    irq_event[IRQ_CARD_ERR]  = card_err_hit;
    irq_event[IRQ_PRE_ERR]   = rx_pre_err;
    irq_event[IRQ_PRE_OK]    = rx_pre_ok;
    irq_event[IRQ_GAP_DONE]  = gap_done;
    irq_event[IRQ_DRIFT_CFG] = man_r.drift && !over16_mode;
    irq_stat_nxt             = irq_stat_r;
    if (wr_en && hit_stat) begin
      irq_stat_nxt = irq_stat_r & ~pwdata[IRQ_W-1:0];
    end
    irq_stat_nxt = irq_stat_nxt | irq_event;
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      irq_stat_r <= '0;
      irq        <= 1'b0;
    end else begin
      irq_stat_r <= irq_stat_nxt;
      irq        <= |(irq_stat_nxt & irq_mask_r);
    end
  end

endmodule

// [tb/ualc_peer.sv]
`timescale 1ns/1ps
module ualc_peer
  import ualc_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       sck_on,
  input  wire logic       send,
  input  wire logic [1:0] kind,
  input  wire logic       pol,
  input  wire logic       bad,
  output logic            sck_tick,
  output logic            rx_sym_valid,
  output ualc_sym_s       rx_sym
);
  logic [1:0] div_r = 2'h0;
  logic [2:0] idx_r = 3'h0;
  logic       busy_r = 1'b0;
  wire  logic bit_w = (kind[1] ? (idx_r[0] ^ kind[0]) : ~kind[0]) ^ pol;

  // quiet line before the first frame
  initial begin
    sck_tick     = 1'b0;
    rx_sym_valid = 1'b0;
    rx_sym       = 2'h1;
  end

  // card clock: a tick every fourth clock while on
  always @(posedge mclk) begin
    div_r    <= sck_on ? div_r + 2'h1 : 2'h0;
    sck_tick <= sck_on && div_r == 2'h3;
  end

  // four cells, every other clock; inverse line between cells
  always @(posedge mclk) begin
    rx_sym_valid <= 1'b0;
    rx_sym       <= ~rx_sym;
    if (send && !busy_r) begin
      busy_r <= 1'b1;
      idx_r  <= 3'h0;
    end else if (busy_r && !rx_sym_valid) begin
      rx_sym       <= {bit_w, bad ? bit_w : ~bit_w};
      rx_sym_valid <= 1'b1;
      idx_r        <= idx_r + 3'h1;
      busy_r       <= idx_r != 3'h3;
    end
  end
endmodule

// [tb/ualc_top_asserts.sv]
`timescale 1ns/1ps
module ualc_top_asserts
  import ualc_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic smartcard_mode,
  input wire logic sck_tick,
  input wire logic bit_tick_in,
  input wire logic baud_tick,
  input wire logic frame_req,
  input wire logic tx_ready,
  input wire logic frame_go,
  input wire logic tx_hold,
  input wire logic tx_pre_active,
  input wire logic rx_sym_valid,
  input wire logic rx_pre_ok,
  input wire logic rx_pre_err,
  input wire logic ir_rx_raw,
  input wire logic ir_rx_clean
);
  default clocking dc @(posedge mclk); endclocking
  default disable iff (sys_rst);

  // one-cycle frame start, then busy
  sequence s_go_done;
    frame_go ##1 (!frame_go && !tx_ready);
  endsequence

  // preamble ends only via frame start
  sequence s_pre_left;
    !$past(sys_rst) && $fell(tx_pre_active);
  endsequence

  go_once_a: assert property (frame_go |-> s_go_done)
    else $error("frame start not single");
  go_cause_a: assert property (frame_go |-> (frame_req && tx_ready) || (tx_pre_active && baud_tick))
    else $error("frame start without cause");
  pre_exit_a: assert property (s_pre_left |-> $past(frame_go))
    else $error("preamble ended without frame");
  hold_idle_a: assert property (tx_hold |-> !tx_ready && !tx_pre_active && !frame_go)
    else $error("activity during guard");
  ready_idle_a: assert property (tx_ready |-> !tx_hold && !tx_pre_active)
    else $error("guard or preamble while idle");
  card_tick_a: assert property (smartcard_mode && baud_tick |-> $past(sck_tick))
    else $error("card tick without serial tick");
  plain_tick_a: assert property (!smartcard_mode |-> baud_tick == bit_tick_in)
    else $error("bit tick not passed through");
  rx_ok_a: assert property (rx_pre_ok |-> $past(rx_sym_valid) && !rx_pre_err)
    else $error("match without received cell");
  ir_follow_a: assert property ($changed(ir_rx_clean) |-> $past(ir_rx_raw) == ir_rx_clean)
    else $error("filter moved off input");
endmodule

bind ualc_top ualc_top_asserts ualc_top_asserts_inst (.*);

// [tb/usart_aux_line_config_test.sv]
`timescale 1ns/1ps
module usart_aux_line_config_test
  import ualc_pkg::*;
;
  logic        mclk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = ZERO_WORD, prdata;
  logic        smartcard_mode = 1'b0, manchester_en = 1'b0, over16_mode = 1'b0, bit_tick_in = 1'b0;
  logic        card_error = 1'b0, frame_req = 1'b0, char_done = 1'b0, ir_rx_raw = 1'b1, tick_on = 1'b0;
  logic        sck_on = 1'b0, send = 1'b0, pol = 1'b0, bad = 1'b0;
  logic [1:0]  kind = 2'h0;
  logic        pready, pslverr, sck_tick, rx_sym_valid, tx_ready, frame_go, tx_hold, tx_pre_active;
  logic        rx_pre_ok, rx_pre_err, ir_rx_clean, baud_tick, drift_enable, irq;
  ualc_sym_s   rx_sym, tx_pre_sym;
  int          errors = 0, samples_checked = 0, cyc = 0;
  typedef struct packed { logic [7:0] a; logic [31:0] d; logic [31:0] q; logic e; } ualc_row_s;
  ualc_row_s   rows [6] = '{
    '{OFS_GAP, 32'hFFFF_FFA5, 32'h0000_00A5, 1'b0},
    '{OFS_RATIO, 32'hFFFF_FFFF, 32'h0000_07FF, 1'b0},
    '{OFS_MAN, 32'hFFFF_FFFF, 32'h530F_130F, 1'b0},
    '{OFS_IRFILT, 32'hFFFF_FF3C, 32'h0000_003C, 1'b0},
    '{OFS_ERRCNT, 32'h0000_00AA, ZERO_WORD, 1'b0},
    '{8'h20, 32'h1234_5678, ZERO_WORD, 1'b1}};

  ualc_top ualc_top_inst (.*);
  ualc_peer ualc_peer_inst (.*);

  // clock
  initial begin
    forever #2 mclk = ~mclk;
  end

  // hang limit, bit tick every fourth clock
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    bit_tick_in <= tick_on && cyc % 4 == 0;
    if (cyc == 20000) begin
      errors++;
      end_of_test();
    end
  end

  task automatic chkw(input string n, input logic [31:0] e, input logic [31:0] s);
    samples_checked++;
    if (s !== e) begin
      errors++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic chkb(input string n, input logic e, input logic s);
    chkw(n, {31'h0, e}, {31'h0, s});
  endtask

  // setup, access until pready, release, one idle cycle
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic rd(input string n, input logic [7:0] a, input logic [31:0] x);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, ZERO_WORD, q, e);
    chkw(n, x, q);
  endtask

  task automatic count(input int n, output int c);
    c = 0;
    repeat (n) begin
      @(posedge mclk);
      if (baud_tick === 1'b1) c++;
    end
  endtask

  task automatic end_of_test();
    $display("compared %0d mismatched %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // main sequence
  initial begin
    logic        ok, er, b;
    logic [31:0] q;
    int          c, i;
    int          gaps [2] = '{3, 0};
    repeat (16) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    chkb("tx_ready", 1'b1, tx_ready);
    chkb("ir_rx_clean", 1'b1, ir_rx_clean);
    rd("ratio_rst", OFS_RATIO, 32'h0000_0174);
    rd("gap_rst", OFS_GAP, ZERO_WORD);
    foreach (rows[r]) begin
      apb(1'b1, rows[r].a, rows[r].d, q, ok);
      chkb("slverr", rows[r].e, ok);
      rd("readback", rows[r].a, rows[r].q);
    end
    $display("register test done");
    wr(OFS_MAN, ZERO_WORD);
    wr(OFS_IRQ_STAT, 32'h0000_001F);
    smartcard_mode <= 1'b1;
    card_error <= 1'b1;
    repeat (3) @(posedge mclk);
    card_error <= 1'b0;
    rd("tally", OFS_ERRCNT, 32'h0000_0003);
    rd("tally_cleared", OFS_ERRCNT, ZERO_WORD);
    chkb("irq_masked", 1'b0, irq);
    wr(OFS_IRQ_MASK, 32'h0000_0001);
    @(posedge mclk);
    chkb("irq_raised", 1'b1, irq);
    wr(OFS_IRQ_STAT, 32'h0000_0001);
    @(posedge mclk);
    chkb("irq_cleared", 1'b0, irq);
    $display("tally test done");
    sck_on <= 1'b1;
    for (int r = 0; r < 5; r++) begin
      wr(OFS_RATIO, r);
      count(24, c);
      count(48, c);
      chkw("card_ticks", (r == 0) ? 0 : 12 / r, c);
    end
    sck_on <= 1'b0;
    smartcard_mode <= 1'b0;
    tick_on <= 1'b1;
    $display("ratio test done");
    foreach (gaps[g]) begin
      wr(OFS_GAP, gaps[g]);
      frame_req <= 1'b1;
      @(posedge mclk);
      chkb("go_plain", 1'b1, frame_go);
      frame_req <= 1'b0;
      char_done <= 1'b1;
      @(posedge mclk);
      char_done <= 1'b0;
      c = 0;
      repeat (40) begin
        @(posedge mclk);
        if (tx_hold === 1'b1 && baud_tick === 1'b1) c++;
      end
      chkw("gap_ticks", gaps[g], c);
      chkb("ready_after", 1'b1, tx_ready);
    end
    $display("guard test done");
    manchester_en <= 1'b1;
    for (int k = 0; k < 8; k++) begin
      wr(OFS_MAN, {19'h0_0000, k[2], 2'h0, k[1:0], 8'h03});
      frame_req <= 1'b1;
      @(posedge mclk);
      frame_req <= 1'b0;
      i = 0;
      c = 0;
      while (i < 3 && c < 60) begin
        @(posedge mclk);
        c++;
        if (tx_pre_active === 1'b1 && baud_tick === 1'b1) begin
          b = (k[1] ? (i[0] ^ k[0]) : ~k[0]) ^ k[2];
          chkw("pre_cell", {30'h0, b, ~b}, {30'h0, tx_pre_sym});
          chkb("pre_go", i == 2, frame_go);
          i++;
        end
      end
      chkw("pre_cells", 32'h0000_0003, i);
      char_done <= 1'b1;
      @(posedge mclk);
      char_done <= 1'b0;
      repeat (3) @(posedge mclk);
    end
    $display("send preamble test done");
    for (int k = 0; k < 10; k++) begin
      wr(OFS_MAN, {3'h0, k[2], 2'h0, k[1:0], 4'h0, (k == 9) ? 4'h0 : 4'h4, 16'h0000});
      kind <= k[1:0];
      pol <= k[2];
      bad <= k == 8;
      send <= 1'b1;
      @(posedge mclk);
      send <= 1'b0;
      ok = 1'b0;
      er = 1'b0;
      repeat (20) begin
        @(posedge mclk);
        ok = ok | rx_pre_ok;
        er = er | rx_pre_err;
      end
      chkb("pre_ok", k < 8, ok);
      chkb("pre_err", k == 8, er);
    end
    $display("receive preamble test done");
    wr(OFS_IRFILT, 32'h0000_0003);
    for (int w = 3; w < 6; w += 2) begin
      ir_rx_raw <= 1'b0;
      ok = 1'b0;
      repeat (w) begin
        @(posedge mclk);
        ok = ok | ~ir_rx_clean;
      end
      ir_rx_raw <= 1'b1;
      repeat (8) begin
        @(posedge mclk);
        ok = ok | ~ir_rx_clean;
      end
      chkb("ir_pass", w == 5, ok);
    end
    $display("filter test done");
    wr(OFS_MAN, 32'h4000_0000);
    chkb("drift_off", 1'b0, drift_enable);
    over16_mode <= 1'b1;
    repeat (2) @(posedge mclk);
    chkb("drift_on", 1'b1, drift_enable);
    $display("drift test done");
    end_of_test();
  end
endmodule
